// ---- logic/rac_core.sv ----
`default_nettype none
module rac_core
  import rac_pkg::*;
#(
  parameter int N = RAC_N,
  parameter int VW = RAC_VW
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire rac_req_t req,
  input wire logic [N*VW-1:0] units_in,
  input wire logic [N-1:0] low_alarm_in,
  input wire logic [N-1:0] high_alarm_in,
  input wire logic [N*4-1:0] range_flags_in,
  output logic rsp_valid,
  output rac_rsp_t rsp,
  output logic cmd_reject,
  output logic cmd_done,
  output logic [1:0] if_mode,
  output logic curve_start,
  output logic [7:0] curve_std,
  output logic [7:0] curve_dest,
  output logic [N-1:0] relay_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RAC_S_IDLE = 2'b00, RAC_S_ALL = 2'b01} rac_state_t;

  rac_state_t state_r, state_nxt;
  logic [3:0] seq_r, seq_nxt;
  logic [1:0] mode_r, mode_nxt;
  rac_relay_cfg_t [N-1:0] cfg_r, cfg_nxt;
  logic [VW-1:0] min_r [N], min_nxt [N];
  logic [VW-1:0] max_r [N], max_nxt [N];
  logic seen_r, seen_nxt;
  logic [N-1:0] relay_r, relay_nxt, relay_act;
  logic rsp_valid_r, rsp_valid_nxt, rej_r, rej_nxt, done_r, done_nxt;
  rac_rsp_t rsp_r, rsp_nxt;
  logic cs_r, cs_nxt;
  logic [7:0] cstd_r, cstd_nxt, cdest_r, cdest_nxt;
  logic [N*VW-1:0] units_s1, units_s2;
  logic [N-1:0] lo_s1, lo_s2, hi_s1, hi_s2;
  logic [N*4-1:0] rng_s1, rng_s2;

  function automatic logic in_range(input logic [3:0] v);
    in_range = (v >= 4'h1) && (v <= 4'(N));
  endfunction : in_range

  function automatic logic [2:0] to_idx(input logic [3:0] v);
    to_idx = 3'(v - 4'h1);
  endfunction : to_idx

  // Pin-side inputs are synchronised; multi-bit values are assumed to change slowly.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      units_s1 <= '0;
      units_s2 <= '0;
      lo_s1 <= '0;
      lo_s2 <= '0;
      hi_s1 <= '0;
      hi_s2 <= '0;
      rng_s1 <= '0;
      rng_s2 <= '0;
    end
    else
    begin
      units_s1 <= units_in;
      units_s2 <= units_s1;
      lo_s1 <= low_alarm_in;
      lo_s2 <= lo_s1;
      hi_s1 <= high_alarm_in;
      hi_s2 <= hi_s1;
      rng_s1 <= range_flags_in;
      rng_s2 <= rng_s1;
    end
  end

  // ----------------------------------------------------------------
  // Relay drive
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++)
  begin : g_rly
    rac_relay u_relay (
      .mode(cfg_r[g].mode),
      .alarm_type(cfg_r[g].alarm_type),
      .low_alarm(lo_s2[cfg_r[g].input_sel]),
      .high_alarm(hi_s2[cfg_r[g].input_sel]),
      .active(relay_act[g])
    );
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [2:0] ix;
    logic [VW-1:0] u;
    ix = to_idx(req.index);
    u = '0;
    state_nxt = state_r;
    seq_nxt = seq_r;
    mode_nxt = mode_r;
    cfg_nxt = cfg_r;
    seen_nxt = 1'b1;
    relay_nxt = relay_act;
    rsp_valid_nxt = 1'b0;
    rsp_nxt = '0;
    rej_nxt = 1'b0;
    done_nxt = 1'b0;
    cs_nxt = 1'b0;
    cstd_nxt = cstd_r;
    cdest_nxt = cdest_r;
    for (int i = 0; i < N; i++)
    begin
      u = units_s2[i*VW +: VW];
      // The first sample after a clear seeds both extremes.
      min_nxt[i] = (!seen_r || u < min_r[i]) ? u : min_r[i];
      max_nxt[i] = (!seen_r || u > max_r[i]) ? u : max_r[i];
    end
    if (state_r == RAC_S_ALL)
    begin
      rsp_valid_nxt = 1'b1;
      rsp_nxt.d0 = units_s2[seq_r*VW +: VW];
      rsp_nxt.seq = seq_r;
      rsp_nxt.last = (seq_r == 4'(N-1));
      seq_nxt = 4'(seq_r + 4'h1);
      if (rsp_nxt.last)
      begin
        state_nxt = RAC_S_IDLE;
        done_nxt = 1'b1;
      end
    end
    else if (req_valid)
    begin
      done_nxt = 1'b1;
      unique case (req.op)
        RAC_C_EXT_CLR: seen_nxt = 1'b0;
        RAC_C_EXT_RD, RAC_C_FLAGS_RD, RAC_C_RLY_RD:
        begin
          if (!in_range(req.index))
            rej_nxt = 1'b1;
          else
          begin
            rsp_valid_nxt = 1'b1;
            rsp_nxt.last = 1'b1;
            if (req.op == RAC_C_EXT_RD)
            begin
              rsp_nxt.d0 = min_r[ix];
              rsp_nxt.d1 = max_r[ix];
            end
            else if (req.op == RAC_C_FLAGS_RD)
            begin
              // Weights 1/2 for alarms and 16..128 for range flags.
              rsp_nxt.d0[RAC_FLAG_LOW] = lo_s2[ix];
              rsp_nxt.d0[RAC_FLAG_HIGH] = hi_s2[ix];
              rsp_nxt.d0[RAC_FLAG_UOVER:RAC_FLAG_TUNDER] = rng_s2[ix*4 +: 4];
            end
            else
            begin
              rsp_nxt.d0 = VW'(cfg_r[ix].mode);
              rsp_nxt.d1 = VW'({1'b0, cfg_r[ix].input_sel} + 4'h1);
              rsp_nxt.d2 = VW'(cfg_r[ix].alarm_type);
            end
          end
        end
        RAC_C_MODE_SET:
        begin
          if (req.arg_a > RAC_MODE_LOCKOUT)
            rej_nxt = 1'b1;
          else
            mode_nxt = req.arg_a;
        end
        RAC_C_MODE_RD:
        begin
          rsp_valid_nxt = 1'b1;
          rsp_nxt.d0 = VW'(mode_r);
          rsp_nxt.last = 1'b1;
        end
        RAC_C_RLY_SET:
        begin
          if (!in_range(req.index) || req.arg_a > RAC_RLY_ALARM ||
              !in_range(req.arg_b) || req.arg_c > RAC_AT_BOTH)
            rej_nxt = 1'b1;
          else
          begin
            cfg_nxt[ix].mode = req.arg_a;
            cfg_nxt[ix].input_sel = to_idx(req.arg_b);
            cfg_nxt[ix].alarm_type = req.arg_c;
          end
        end
        RAC_C_RLYST_RD:
        begin
          rsp_valid_nxt = 1'b1;
          rsp_nxt.d0 = VW'(relay_r);
          rsp_nxt.last = 1'b1;
        end
        RAC_C_UNITS_RD:
        begin
          if (req.index == RAC_ALL_INPUTS)
          begin
            // Streaming all inputs in one burst suits the host's peak-rate reads.
            state_nxt = RAC_S_ALL;
            seq_nxt = 4'h0;
            done_nxt = 1'b0;
          end
          else if (!in_range(req.index))
            rej_nxt = 1'b1;
          else
          begin
            rsp_valid_nxt = 1'b1;
            rsp_nxt.d0 = units_s2[ix*VW +: VW];
            rsp_nxt.last = 1'b1;
          end
        end
        RAC_C_CURVE:
        begin
          if (!(req.std_curve == RAC_STD_A || req.std_curve == RAC_STD_B ||
                req.std_curve == RAC_STD_C) || req.dest_curve < RAC_DEST_MIN ||
              req.dest_curve > RAC_DEST_MAX || req.sn_len > RAC_SN_MAX)
            rej_nxt = 1'b1;
          else
          begin
            // Point pairs travel on the curve builder's own path; no response here.
            cs_nxt = 1'b1;
            cstd_nxt = req.std_curve;
            cdest_nxt = req.dest_curve;
          end
        end
        default: rej_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= RAC_S_IDLE;
      seq_r <= '0;
      mode_r <= RAC_MODE_RST;
      cfg_r <= '0;
      seen_r <= 1'b0;
      relay_r <= '0;
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
      rej_r <= 1'b0;
      done_r <= 1'b0;
      cs_r <= 1'b0;
      cstd_r <= '0;
      cdest_r <= '0;
      for (int i = 0; i < N; i++)
      begin
        min_r[i] <= '0;
        max_r[i] <= '0;
      end
    end
    else
    begin
      state_r <= state_nxt;
      seq_r <= seq_nxt;
      mode_r <= mode_nxt;
      cfg_r <= cfg_nxt;
      seen_r <= seen_nxt;
      relay_r <= relay_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r <= rsp_nxt;
      rej_r <= rej_nxt;
      done_r <= done_nxt;
      cs_r <= cs_nxt;
      cstd_r <= cstd_nxt;
      cdest_r <= cdest_nxt;
      for (int i = 0; i < N; i++)
      begin
        min_r[i] <= min_nxt[i];
        max_r[i] <= max_nxt[i];
      end
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign cmd_reject = rej_r;
  assign cmd_done = done_r;
  assign if_mode = mode_r;
  assign curve_start = cs_r;
  assign curve_std = cstd_r;
  assign curve_dest = cdest_r;
  assign relay_out = relay_r;
endmodule : rac_core
`default_nettype wire

// ---- logic/rac_pkg.sv ----
// Functional notes
// - Extremes clear wipes all min/max, silent.
// - Extremes query returns minimum then maximum.
// - Mode codes: 0 local, 1 remote, 2 lockout.
// - Mode query returns current mode code.
// - Input flags weights 16,32,64,128 for ranges.
// - Relay config: relay 1-8, mode off/on/alarm.
// - Alarm mode relay follows one chosen input.
// - Alarm type: 0 low, 1 high, 2 both.
// - Relay query returns mode, input, type.
// - Relay status: relay n is bit n-1.
// - Units query: 1-8 single, 0 all eight.
// - Curve command: source 1/6/7, dest 21-28, serial <=10.
// - Curve command takes three point pairs, silent.
// - Alarm weights: 1 low, 2 high.
`default_nettype none
package rac_pkg;
  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int RAC_N = 8;
  localparam int RAC_VW = 16;
  localparam logic [3:0] RAC_ALL_INPUTS = 4'h0;
  localparam logic [1:0] RAC_MODE_LOCAL = 2'h0;
  localparam logic [1:0] RAC_MODE_REMOTE = 2'h1;
  localparam logic [1:0] RAC_MODE_LOCKOUT = 2'h2;
  localparam logic [1:0] RAC_RLY_OFF = 2'h0;
  localparam logic [1:0] RAC_RLY_ON = 2'h1;
  localparam logic [1:0] RAC_RLY_ALARM = 2'h2;
  localparam logic [1:0] RAC_AT_LOW = 2'h0;
  localparam logic [1:0] RAC_AT_HIGH = 2'h1;
  localparam logic [1:0] RAC_AT_BOTH = 2'h2;
  localparam int RAC_FLAG_LOW = 0;
  localparam int RAC_FLAG_HIGH = 1;
  localparam int RAC_FLAG_TUNDER = 4;
  localparam int RAC_FLAG_TOVER = 5;
  localparam int RAC_FLAG_UUNDER = 6;
  localparam int RAC_FLAG_UOVER = 7;
  localparam logic [7:0] RAC_STD_A = 8'h01;
  localparam logic [7:0] RAC_STD_B = 8'h06;
  localparam logic [7:0] RAC_STD_C = 8'h07;
  localparam logic [7:0] RAC_DEST_MIN = 8'h15;
  localparam logic [7:0] RAC_DEST_MAX = 8'h1c;
  localparam logic [3:0] RAC_SN_MAX = 4'ha;
  localparam logic [1:0] RAC_MODE_RST = 2'h0;

  typedef enum logic [3:0] {
    RAC_C_NONE = 4'h0,
    RAC_C_EXT_CLR = 4'h1,
    RAC_C_EXT_RD = 4'h2,
    RAC_C_MODE_SET = 4'h3,
    RAC_C_MODE_RD = 4'h4,
    RAC_C_FLAGS_RD = 4'h5,
    RAC_C_RLY_SET = 4'h6,
    RAC_C_RLY_RD = 4'h7,
    RAC_C_RLYST_RD = 4'h8,
    RAC_C_UNITS_RD = 4'h9,
    RAC_C_CURVE = 4'ha
  } rac_cmd_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] input_sel;
    logic [1:0] alarm_type;
  } rac_relay_cfg_t;

  typedef struct packed {
    rac_cmd_t op;
    logic [3:0] index;
    logic [1:0] arg_a;
    logic [3:0] arg_b;
    logic [1:0] arg_c;
    logic [7:0] std_curve;
    logic [7:0] dest_curve;
    logic [3:0] sn_len;
  } rac_req_t;

  typedef struct packed {
    logic [RAC_VW-1:0] d0;
    logic [RAC_VW-1:0] d1;
    logic [RAC_VW-1:0] d2;
    logic [3:0] seq;
    logic last;
  } rac_rsp_t;
endpackage : rac_pkg
`default_nettype wire

// ---- logic/rac_relay.sv ----
`default_nettype none
module rac_relay
  import rac_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic [1:0] alarm_type,
  input wire logic low_alarm,
  input wire logic high_alarm,
  output logic active
);
  always_comb
  begin
    active = 1'b0;
    unique case (mode)
      RAC_RLY_ON: active = 1'b1;
      RAC_RLY_ALARM:
      begin
        unique case (alarm_type)
          RAC_AT_LOW: active = low_alarm;
          RAC_AT_HIGH: active = high_alarm;
          RAC_AT_BOTH: active = low_alarm | high_alarm;
          default: active = 1'b0;
        endcase
      end
      default: active = 1'b0;
    endcase
  end
endmodule : rac_relay
`default_nettype wire

// ---- dv/rac_host.sv ----
`default_nettype none
module rac_host
  import rac_pkg::*;
(
  input wire logic clk,
  output logic req_valid,
  output rac_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  // Idle fields get the inverse pattern so stale values cannot pass.
  task automatic send(input rac_req_t r);
    @(negedge clk);
    req_valid = 1'b1;
    req = r;
    @(negedge clk);
    req_valid = 1'b0;
    req = ~r;
  endtask : send
endmodule : rac_host
`default_nettype wire

// ---- dv/rac_core_chk.sv ----
`default_nettype none
module rac_core_chk
  import rac_pkg::*;
#(
  parameter int N = RAC_N,
  parameter int VW = RAC_VW
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire rac_req_t req,
  input wire logic rsp_valid,
  input wire rac_rsp_t rsp,
  input wire logic cmd_reject,
  input wire logic cmd_done,
  input wire logic [1:0] if_mode,
  input wire logic curve_start,
  input wire logic [7:0] curve_std,
  input wire logic [7:0] curve_dest,
  input wire logic [N-1:0] relay_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_REJ: assert property (cmd_reject |-> cmd_done && !rsp_valid && $stable(if_mode))
    else $error("reject had side effects");
  AST_MODE_OK: assert property (if_mode != 2'h3)
    else $error("illegal mode code");
  AST_MODE_SET: assert property (
    req_valid && req.op == RAC_C_MODE_SET && req.index == 4'h1 && req.arg_a != 2'h3
    |=> if_mode == $past(req.arg_a) && !cmd_reject) else $error("mode not taken");
  AST_MODE_RD: assert property (
    req_valid && req.op == RAC_C_MODE_RD && req.index == 4'h1
    |=> rsp_valid && rsp.d0 == VW'(if_mode) && rsp.last && cmd_done) else $error("mode read");
  AST_EXT_CLR: assert property (
    req_valid && req.op == RAC_C_EXT_CLR && req.index == 4'h1 |=> cmd_done && !rsp_valid)
    else $error("clear not silent");
  AST_CURVE: assert property (curve_start |-> !rsp_valid && curve_dest >= 8'h15 &&
    curve_dest <= 8'h1c && curve_std inside {8'h01, 8'h06, 8'h07}) else $error("curve args");
  AST_STAT: assert property (
    req_valid && req.op == RAC_C_RLYST_RD && req.index == 4'h1
    |=> rsp_valid && rsp.d0 == VW'($past(relay_out))) else $error("relay status");
  AST_ALL: assert property (
    req_valid && req.op == RAC_C_UNITS_RD && req.index == 4'h0 |-> ##2 rsp_valid &&
    rsp.seq == 4'h0 ##7 rsp_valid && rsp.last && rsp.seq == 4'h7 && cmd_done)
    else $error("stream frame");
  AST_SEQ: assert property (
    rsp_valid && !rsp.last |=> rsp_valid && rsp.seq == $past(rsp.seq) + 4'h1)
    else $error("stream order");
  COV_ALL: cover property (rsp_valid && rsp.last && rsp.seq == 4'h7);
  COV_REJ: cover property (cmd_reject);
  COV_CURVE: cover property (curve_start);
endmodule : rac_core_chk
bind rac_core rac_core_chk #(.N(N), .VW(VW)) u_chk (.clk, .rst_b, .req_valid, .req,
  .rsp_valid, .rsp, .cmd_reject, .cmd_done, .if_mode, .curve_start, .curve_std,
  .curve_dest, .relay_out);
`default_nettype wire

// ---- dv/rac_core_bench.sv ----
`default_nettype none
module rac_core_bench
  import rac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid, rsp_valid, cmd_reject, cmd_done, curve_start;
  rac_req_t req, q;
  rac_rsp_t rsp;
  logic [127:0] units_in = '0;
  logic [7:0] low_alarm_in = '0, high_alarm_in = '0, curve_std, curve_dest, relay_out, e;
  logic [31:0] range_flags_in = '0;
  logic [1:0] if_mode;
  logic [1:0] rm[8] = '{default: 2'h0};
  logic [3:0] ri[8] = '{default: 4'h1};
  logic [1:0] rt[8] = '{default: 2'h0};
  int num_errors = 0, n_tests = 0, r;
  logic bad;
  always #50 clk = ~clk;
  rac_host host (
    .clk(clk),
    .req_valid(req_valid),
    .req(req)
  );
  rac_core DUT (
    .clk(clk),
    .rst_b(rst_b),
    .req_valid(req_valid),
    .req(req),
    .units_in(units_in),
    .low_alarm_in(low_alarm_in),
    .high_alarm_in(high_alarm_in),
    .range_flags_in(range_flags_in),
    .rsp_valid(rsp_valid),
    .rsp(rsp),
    .cmd_reject(cmd_reject),
    .cmd_done(cmd_done),
    .if_mode(if_mode),
    .curve_start(curve_start),
    .curve_std(curve_std),
    .curve_dest(curve_dest),
    .relay_out(relay_out)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [15:0] x, input logic [15:0] g);
    n_tests++;
    if (g !== x)
    begin
      num_errors++;
      $display("FAIL %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task automatic go(input rac_cmd_t o, input logic [3:0] x);
    q.op = o;
    q.index = x;
    host.send(q);
  endtask : go
  function automatic logic exp_rly(input int k);
    logic l, h;
    l = low_alarm_in[ri[k]-4'h1];
    h = high_alarm_in[ri[k]-4'h1];
    if (rm[k] != 2'h2)
      return rm[k] == 2'h1;
    return rt[k] == 2'h0 ? l : rt[k] == 2'h1 ? h : l | h;
  endfunction : exp_rly
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    r = $urandom(32'h186a078b);
    q = '0;
    repeat (12) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    for (int m = 3; m >= 0; m--)
    begin
      q.arg_a = 2'(m);
      go(RAC_C_MODE_SET, 4'h1);
      chk("mode reject", 16'(m == 3), 16'(cmd_reject));
      go(RAC_C_MODE_RD, 4'h1);
      chk("mode", m == 3 ? 16'h0 : 16'(m), rsp.d0);
    end
    $display("test mode done");
    for (int k = 0; k < 30; k++)
    begin
      r = $urandom_range(7);
      q.arg_a = 2'($urandom_range(2));
      q.arg_b = 4'($urandom_range(8, 1));
      q.arg_c = k == 0 ? 2'h3 : 2'($urandom_range(2));
      bad = k < 2;
      go(RAC_C_RLY_SET, k == 1 ? 4'h9 : 4'(r + 1));
      chk("relay reject", 16'(bad), 16'(cmd_reject));
      if (!bad)
      begin
        rm[r] = q.arg_a;
        ri[r] = q.arg_b;
        rt[r] = q.arg_c;
      end
      low_alarm_in = 8'($urandom);
      high_alarm_in = 8'($urandom);
      repeat (6) @(negedge clk);
      for (int i = 0; i < 8; i++)
        e[i] = exp_rly(i);
      chk("relays", {8'h0, e}, {8'h0, relay_out});
      go(RAC_C_RLY_RD, 4'(r + 1));
      chk("relay mode", 16'(rm[r]), rsp.d0);
      chk("relay input", 16'(ri[r]), rsp.d1);
      chk("relay type", 16'(rt[r]), rsp.d2);
      go(RAC_C_RLYST_RD, 4'h1);
      chk("relay status", {8'h0, e}, rsp.d0);
    end
    $display("test relays done");
    range_flags_in = $urandom;
    units_in = {$urandom, $urandom, $urandom, $urandom};
    repeat (6) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      go(RAC_C_FLAGS_RD, 4'(i + 1));
      chk("flags", {8'h0, range_flags_in[i*4 +: 4], 2'h0, high_alarm_in[i], low_alarm_in[i]},
        rsp.d0);
      go(RAC_C_UNITS_RD, 4'(i + 1));
      chk("units", units_in[i*16 +: 16], rsp.d0);
    end
    go(RAC_C_UNITS_RD, 4'h0);
    // The first word of a stream leaves one cycle after the request is taken.
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      chk("all units", units_in[i*16 +: 16], rsp.d0);
      chk("word tag", {10'h0, i == 7, i == 7, 4'(i)}, {10'h0, cmd_done, rsp.last, rsp.seq});
    end
    $display("test readings done");
    units_in[15:0] = 16'h1234;
    repeat (6) @(negedge clk);
    go(RAC_C_EXT_CLR, 4'h1);
    chk("clear silent", 16'h0, 16'(rsp_valid));
    repeat (4) @(negedge clk);
    units_in[15:0] = 16'h9abc;
    repeat (6) @(negedge clk);
    go(RAC_C_EXT_RD, 4'h1);
    chk("min", 16'h1234, rsp.d0);
    chk("max", 16'h9abc, rsp.d1);
    go(RAC_C_EXT_RD, 4'h8);
    chk("min8", units_in[127:112], rsp.d0);
    chk("max8", units_in[127:112], rsp.d1);
    $display("test extremes done");
    for (int i = 0; i < 5; i++)
    begin
      q.std_curve = i == 0 ? 8'h01 : i == 1 ? 8'h06 : 8'h07;
      q.dest_curve = i == 3 ? 8'h1d : 8'h15 + 8'(i);
      q.sn_len = i == 4 ? 4'hb : 4'ha;
      go(RAC_C_CURVE, 4'h1);
      chk("curve start", {14'h0, i < 3, 1'b0}, {14'h0, curve_start, rsp_valid});
      chk("curve args", i < 3 ? {q.std_curve, q.dest_curve} : 16'h0717,
        {curve_std, curve_dest});
    end
    $display("test curve done");
    q.arg_a = 2'h2;
    q.arg_b = 4'h0;
    q.arg_c = 2'h0;
    go(RAC_C_RLY_SET, 4'h1);
    chk("relay input reject", 16'h1, 16'(cmd_reject));
    go(RAC_C_RLY_RD, 4'h1);
    chk("relay kept", 16'(ri[0]), rsp.d1);
    go(RAC_C_NONE, 4'h1);
    chk("op reject", 16'h1, 16'(cmd_reject));
    go(RAC_C_UNITS_RD, 4'h9);
    chk("index reject", 16'h1, 16'(cmd_reject));
    go(RAC_C_FLAGS_RD, 4'h0);
    chk("flags reject", 16'h1, 16'(cmd_reject));
    $display("test rejects done");
    finish_test();
  end
endmodule : rac_core_bench
`default_nettype wire
